// file: hw/fault_flag_consts.svh
// Register map, field positions, reset values and rule notes for the fault flag bank
// Notes on behaviour
// R1: Key 1011 in bits 6:3 resets registers
// R2: Key field reads back zero afterwards
// R3: Policy bit zero: faults shut converter down
// R4: Policy bit one: faults only reported
// R5: Hard short always shuts buck/boost down
// R6: Host sets policy bit before enabling converters
// R7: Regulator overvolt flags bits 7:4, both edges
// R8: Regulator undervolt flags bits 3:0, both edges
// R9: Event flags sticky, cleared by register read
// R10: Converter over/undervolt flags bits 7:4
// R11: Regulator overcurrent flags bits 3:0
// R12: Converter peak current flags bits 7:6
// R13: Main input lockout flag bit 5
// R14: Regulator input lockout flags bits 4:2
// R15: Thermal trip and warning flags bits 1:0
// R16: Live regulator voltage state register
// R17: Live converter voltage and current register
// R18: Live peak current bits 7:6
// R19: Live lockout bits 5:2
// R20: Live thermal bits 1:0
// R21: Mask bits, zero default, gate interrupt pin
// R22: Interrupt pin low while unmasked flag set
`ifndef FAULT_FLAG_CONSTS_SVH
`define FAULT_FLAG_CONSTS_SVH
`define OFS_POLICY      8'h10
`define OFS_EVENT1      8'h11
`define OFS_EVENT2      8'h12
`define OFS_EVENT3      8'h13
`define OFS_LIVE1       8'h14
`define OFS_LIVE2       8'h15
`define OFS_LIVE3       8'h16
`define OFS_MASK1       8'h17
`define OFS_MASK2       8'h18
`define OFS_MASK3       8'h19
`define SRST_MSB        6
`define SRST_LSB        3
`define SRST_KEY        4'hB
`define POLICY_BIT      0
`define REG_RESET       8'h00
`endif

// file: hw/fault_flag_pkg.sv
// Types shared by the fault flag bank
`default_nettype none
package fault_flag_pkg;
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;
   typedef struct packed {
      logic [7:0] ev1;
      logic [7:0] ev2;
      logic [7:0] ev3;
   } events_t;
endpackage
`default_nettype wire

// file: hw/pmic_fault_flag_bank.sv
// Sticky event flags, live status, masks, soft reset and fault shutdown policy
`include "fault_flag_consts.svh"
`default_nettype none
module pmic_fault_flag_bank
   import fault_flag_pkg::*;
(
   input  wire logic       CLK_I,
   input  wire logic       RST_N_I,
   input  wire reg_req_t   REQ_I,
   output logic [7:0]      RDATA_O,
   input  wire events_t    EVENT_I,
   input  wire events_t    LIVE_I,
   input  wire logic [1:0] HARD_SHORT_I,
   output logic [5:0]      SHUTDOWN_O,
   output logic            FAULT_SHUTDOWN_DISABLE_O,
   output logic            IRQ_OUT_N_O
);
   // ----------------------------------------------------------------
   // Input synchronisers: three stages, change taken when 2 and 3 agree
   // ----------------------------------------------------------------
   events_t ev_s1_q, ev_s2_q, ev_s3_q, ev_q;
   events_t lv_s1_q, lv_s2_q, lv_s3_q, lv_q;
   logic [1:0] hs_s1_q, hs_s2_q, hs_s3_q, hs_q;
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         ev_s1_q <= '0;
         ev_s2_q <= '0;
         ev_s3_q <= '0;
         ev_q    <= '0;
         lv_s1_q <= '0;
         lv_s2_q <= '0;
         lv_s3_q <= '0;
         lv_q    <= '0;
         hs_s1_q <= '0;
         hs_s2_q <= '0;
         hs_s3_q <= '0;
         hs_q    <= '0;
      end else begin
         ev_s1_q <= EVENT_I;
         ev_s2_q <= ev_s1_q;
         ev_s3_q <= ev_s2_q;
         lv_s1_q <= LIVE_I;
         lv_s2_q <= lv_s1_q;
         lv_s3_q <= lv_s2_q;
         hs_s1_q <= HARD_SHORT_I;
         hs_s2_q <= hs_s1_q;
         hs_s3_q <= hs_s2_q;
         if (ev_s2_q == ev_s3_q) begin
            ev_q <= ev_s3_q;
         end
         if (lv_s2_q == lv_s3_q) begin
            lv_q <= lv_s3_q;
         end
         if (hs_s2_q == hs_s3_q) begin
            hs_q <= hs_s3_q;
         end
      end
   end

   // ----------------------------------------------------------------
   // Register decode
   // ----------------------------------------------------------------
   wire wr_policy = REQ_I.wr && REQ_I.addr == `OFS_POLICY;
   wire soft_rst  = wr_policy && REQ_I.wdata[`SRST_MSB:`SRST_LSB] == `SRST_KEY; // R1
   wire rd_ev1    = REQ_I.rd && REQ_I.addr == `OFS_EVENT1;
   wire rd_ev2    = REQ_I.rd && REQ_I.addr == `OFS_EVENT2;
   wire rd_ev3    = REQ_I.rd && REQ_I.addr == `OFS_EVENT3;
   // Rising edge of each detector pulse (a detector pulses on entry and on recovery)
   events_t ev_prev_q;
   wire [23:0] ev_rise = ev_q & ~ev_prev_q;

   logic       policy_q;
   logic [7:0] flag1_q, flag2_q, flag3_q;
   logic [7:0] mask1_q, mask2_q, mask3_q;
   logic [7:0] rdata_q;

   // ----------------------------------------------------------------
   // Sticky flags: set wins over read clear
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         ev_prev_q <= '0;
         flag1_q   <= `REG_RESET;
         flag2_q   <= `REG_RESET;
         flag3_q   <= `REG_RESET;
      end else begin
         ev_prev_q <= ev_q;
         if (soft_rst) begin // R1
            flag1_q <= `REG_RESET;
            flag2_q <= `REG_RESET;
            flag3_q <= `REG_RESET;
         end else begin
            // R7 R8 R9
            flag1_q <= (rd_ev1 ? 8'h00 : flag1_q) | ev_rise[23:16];
            // R10 R11
            flag2_q <= (rd_ev2 ? 8'h00 : flag2_q) | ev_rise[15:8];
            // R12 R13 R14 R15
            flag3_q <= (rd_ev3 ? 8'h00 : flag3_q) | ev_rise[7:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Masks and policy; the key field is not stored so it reads zero
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         policy_q <= 1'b0;
         mask1_q  <= `REG_RESET;
         mask2_q  <= `REG_RESET;
         mask3_q  <= `REG_RESET;
      end else if (soft_rst) begin
         policy_q <= 1'b0; // R1 R2
         mask1_q  <= `REG_RESET;
         mask2_q  <= `REG_RESET;
         mask3_q  <= `REG_RESET;
      end else if (REQ_I.wr) begin
         if (wr_policy) begin
            policy_q <= REQ_I.wdata[`POLICY_BIT];
         end
         if (REQ_I.addr == `OFS_MASK1) begin
            mask1_q <= REQ_I.wdata; // R21
         end
         if (REQ_I.addr == `OFS_MASK2) begin
            mask2_q <= REQ_I.wdata;
         end
         if (REQ_I.addr == `OFS_MASK3) begin
            mask3_q <= REQ_I.wdata;
         end
      end
   end

   // ----------------------------------------------------------------
   // Read data: live state passes straight through
   // ----------------------------------------------------------------
   logic [7:0] rmux;
   always_comb begin
      unique case (REQ_I.addr)
         `OFS_POLICY: rmux = {7'h00, policy_q}; // R2
         `OFS_EVENT1: rmux = flag1_q;
         `OFS_EVENT2: rmux = flag2_q;
         `OFS_EVENT3: rmux = flag3_q;
         `OFS_LIVE1:  rmux = lv_q.ev1; // R16
         `OFS_LIVE2:  rmux = lv_q.ev2; // R17
         `OFS_LIVE3:  rmux = lv_q.ev3; // R18 R19 R20
         `OFS_MASK1:  rmux = mask1_q;
         `OFS_MASK2:  rmux = mask2_q;
         `OFS_MASK3:  rmux = mask3_q;
         default:     rmux = 8'h00;
      endcase
   end
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) rdata_q <= 8'h00;
      else if (REQ_I.rd) rdata_q <= rmux;
   end
   assign RDATA_O = rdata_q;

   // ----------------------------------------------------------------
   // Shutdown: {stepup, stepdown, reg4..reg1}
   // ----------------------------------------------------------------
   wire [5:0] fault_live = {lv_q.ev2[7] | lv_q.ev2[5],
                            lv_q.ev2[6] | lv_q.ev2[4],
                            lv_q.ev1[7:4] | lv_q.ev1[3:0] | lv_q.ev2[3:0]};
   assign SHUTDOWN_O = (policy_q ? 6'h00 : fault_live) // R3 R4
                       | {hs_q, 4'h0}; // R5
   assign FAULT_SHUTDOWN_DISABLE_O = policy_q;

   wire pend1   = |(flag1_q & ~mask1_q);
   wire pend2   = |(flag2_q & ~mask2_q);
   wire pend3   = |(flag3_q & ~mask3_q);
   wire pending = pend1 | pend2 | pend3;
   assign IRQ_OUT_N_O = ~pending; // R21 R22

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   key_clears_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // R1
      soft_rst |=> (flag1_q == 8'h00 && mask1_q == 8'h00 && !policy_q))
      else $error("soft reset did not clear registers");
   key_reads_zero_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // R2
      (REQ_I.rd && REQ_I.addr == `OFS_POLICY) |=> rdata_q[7:1] == 7'h00)
      else $error("key field read back non-zero");
   shut_on_fault_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // R3
      (!policy_q && lv_q.ev1[0]) |-> SHUTDOWN_O[0])
      else $error("regulator not shut down on fault");
   keep_running_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // R4
      (policy_q && !hs_q[0]) |-> !SHUTDOWN_O[4])
      else $error("converter shut down while policy disabled");
   short_shuts_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // R5
      hs_q[1] |-> SHUTDOWN_O[5])
      else $error("hard short ignored");
   flag_sticky_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // R9
      (flag1_q[0] && !rd_ev1 && !soft_rst) |=> flag1_q[0])
      else $error("flag lost without read");
   flag_sets_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // R7
      (ev_rise[23] && !soft_rst) |=> flag1_q[7])
      else $error("event not latched");
   irq_follow_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // R22
      (flag3_q[1] && !mask3_q[1]) |-> !IRQ_OUT_N_O)
      else $error("interrupt not asserted");
   mask_gate_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // R21
      (flag2_q == 8'h00 && flag3_q == 8'h00 && (flag1_q & ~mask1_q) == 8'h00) |-> IRQ_OUT_N_O)
      else $error("masked flag drove interrupt");
   live_pass_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // R16
      (REQ_I.rd && REQ_I.addr == `OFS_LIVE1) |=> rdata_q == $past(lv_q.ev1))
      else $error("live status mismatch");
   uv_sets_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // R8
      (ev_rise[16] && !soft_rst) |=> flag1_q[0])
      else $error("undervoltage event not latched");
   conv_ov_sets_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // R10
      (ev_rise[15] && !soft_rst) |=> flag2_q[7])
      else $error("converter event not latched");
   oc_sets_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // R11
      (ev_rise[8] && !soft_rst) |=> flag2_q[0])
      else $error("overcurrent event not latched");
   peak_sets_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // R12
      (ev_rise[7] && !soft_rst) |=> flag3_q[7])
      else $error("peak event not latched");
   main_lock_sets_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // R13
      (ev_rise[5] && !soft_rst) |=> flag3_q[5])
      else $error("main lockout event not latched");
   reg_lock_sets_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // R14
      (ev_rise[2] && !soft_rst) |=> flag3_q[2])
      else $error("regulator lockout event not latched");
   thermal_sets_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // R15
      (ev_rise[1] && !soft_rst) |=> flag3_q[1])
      else $error("thermal event not latched");
   read_clears_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // R9
      (rd_ev2 && ev_rise[15:8] == 8'h00 && !soft_rst) |=> flag2_q == 8'h00)
      else $error("read did not clear flags");
   live_conv_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // R17
      (REQ_I.rd && REQ_I.addr == `OFS_LIVE2) |=> rdata_q == $past(lv_q.ev2))
      else $error("live converter status mismatch");
   live_supply_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // R18 R19 R20
      (REQ_I.rd && REQ_I.addr == `OFS_LIVE3) |=> rdata_q == $past(lv_q.ev3))
      else $error("live supply status mismatch");
   conv_shut_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // R3
      (!policy_q && lv_q.ev2[7]) |-> SHUTDOWN_O[5])
      else $error("converter not shut down on fault");
   regs_run_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // R4
      policy_q |-> SHUTDOWN_O[3:0] == 4'h0)
      else $error("regulator shut down while policy disabled");
   down_short_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // R5
      hs_q[0] |-> SHUTDOWN_O[4])
      else $error("hard short ignored");
   key_clears_more_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // R1
      soft_rst |=> (flag2_q == 8'h00 && flag3_q == 8'h00 && mask3_q == 8'h00))
      else $error("soft reset left registers set");
   irq_first_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // R22
      (flag1_q[4] && !mask1_q[4]) |-> !IRQ_OUT_N_O)
      else $error("interrupt not asserted");
   irq_second_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // R22
      (flag2_q[3] && !mask2_q[3]) |-> !IRQ_OUT_N_O)
      else $error("interrupt not asserted");
endmodule
`default_nettype wire

// file: verification/pmic_fault_flag_bank_bench.sv
// Self-checking bench for the fault flag bank
`default_nettype none
module pmic_fault_flag_bank_bench;
   import fault_flag_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk = 0;
   logic       rst_n = 0;
   reg_req_t   req;
   logic [7:0] rdata;
   events_t    ev, lv;
   logic [1:0] hs;
   logic [5:0] sd;
   logic       fsd, irq_n;
   int         fails = 0, checks = 0, cyc = 0, g, b, s;
   always #12.5 clk = ~clk;
   reg_host host (.clk_i(clk), .req_o(req));
   pmic_fault_flag_bank dut (.CLK_I(clk), .RST_N_I(rst_n), .REQ_I(req), .RDATA_O(rdata),
      .EVENT_I(ev), .LIVE_I(lv), .HARD_SHORT_I(hs), .SHUTDOWN_O(sd),
      .FAULT_SHUTDOWN_DISABLE_O(fsd), .IRQ_OUT_N_O(irq_n));
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] v);
      checks++;
      if (v !== e) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, v);
      end
   endtask
   task automatic test_done;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      host.xfer(1'b0, a, 8'h00);
      chk($sformatf("reg %h", a), e, rdata);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      host.xfer(1'b1, a, d);
   endtask
   // Detector pulse long enough to pass the input synchronisers
   task automatic pulse(input int g, input int b);
      ev[(3 - g) * 8 + b] = 1'b1;
      wt(6);
      ev[(3 - g) * 8 + b] = 1'b0;
      wt(6);
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc > 4000) begin
         fails++;
         test_done();
      end
   end
   initial begin
      ev = '0;
      lv = '0;
      hs = '0;
      s = $urandom(32'h29e1_1e89);
      wt(2);
      rst_n = 1;
      for (int a = 17; a <= 22; a++) rd(8'(a), 8'h00);
      for (int i = 0; i < 14; i++) begin
         g = $urandom_range(3, 1);
         b = $urandom_range(7, 0);
         if (i[0]) wr(8'(8'h16 + g), 8'(1 << b));
         pulse(g, b);
         chk("irq_n", {7'h00, i[0]}, {7'h00, irq_n});
         rd(8'(8'h10 + g), 8'(1 << b));
         rd(8'(8'h10 + g), 8'h00);
         chk("irq_n", 8'h01, {7'h00, irq_n});
         if (i[0]) wr(8'(8'h16 + g), 8'h00);
      end
      for (int i = 0; i < 4; i++) begin
         lv = events_t'(24'($urandom));
         wt(6);
         rd(8'h14, lv.ev1);
         rd(8'h15, lv.ev2);
         rd(8'h16, lv.ev3);
      end
      lv = '0;
      lv[20] = 1'b1;
      wt(6);
      chk("shutdown", 8'h01, {2'b00, sd});
      wr(8'h10, 8'h01);
      wt(1);
      chk("shutdown", 8'h00, {2'b00, sd});
      hs = 2'b10;
      wt(6);
      chk("shutdown", 8'h20, {2'b00, sd});
      pulse(1, 0);
      wr(8'h10, 8'h51);
      rd(8'h10, 8'h01);
      wr(8'h10, 8'h58);
      wt(1);
      chk("policy", 8'h00, {7'h00, fsd});
      rd(8'h10, 8'h00);
      rd(8'h11, 8'h00);
      chk("irq_n", 8'h01, {7'h00, irq_n});
      test_done();
   end
endmodule
`default_nettype wire

// file: verification/reg_host.sv
// Host model that issues one-cycle register requests
`default_nettype none
module reg_host
   import fault_flag_pkg::*;
(
   input  wire logic   clk_i,
   output var reg_req_t req_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial req_o = '0;
   // Strobe raised after an edge, held across exactly one sampling edge
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      #1 req_o = '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge clk_i);
      #1 req_o = '0;
   endtask
endmodule
`default_nettype wire
